/* core/eeprom_host_defs.svh */
// Timing and layout constants for the byte-wide EEPROM host controller.
`ifndef EEPROM_HOST_DEFS_SVH
`define EEPROM_HOST_DEFS_SVH
`define CLK_PERIOD_NS      20
`define ADDR_W             11
`define DATA_W             8
`define PAGE_LSB_W         4
`define POLL_BIT           7
`define STROBE_NS          100
`define STROBE_CYC         ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_NS          200
`define ACCESS_CYC         ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAGE_GAP_US        20
`define PAGE_GAP_CYC       ((`PAGE_GAP_US * 1000) / `CLK_PERIOD_NS)
`define PROG_MAX_MS        10
`define PROG_MAX_CYC       ((`PROG_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`endif

/* core/eeprom_host_pkg.sv */
// Types shared by the byte-wide EEPROM host controller.
`default_nettype none
package eeprom_host_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        last;
        logic [10:0] addr;
        logic [7:0]  wdata;
    } host_req_t;

    typedef struct packed {
        logic       done;
        logic       timeout;
        logic [7:0] rdata;
    } host_rsp_t;

    typedef struct packed {
        logic        cs_n;
        logic        oe_n;
        logic        we_n;
        logic [10:0] byte_address_lines;
        logic [7:0]  dout;
        logic        doe;
    } mem_pins_t;
endpackage
`default_nettype wire

/* core/eeprom_host.sv */
// Host controller driving a byte-wide EEPROM through its pins.
// ----------------------------------------------------------------
// Notes on behaviour
// - Read holds select and output-enable low, strobe high; lifting either ends it.
// - Write starts only with select and strobe low, output-enable high.
// - After the first byte, up to fifteen more bytes join one page.
// - Address bits four to ten stay equal across one page.
// - Next strobe fall of a page comes within 20 us of the last.
// - Output-enable low, strobe high or select high block writes.
// - Select is the per-device line; output-enable and strobe are shared.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_host_defs.svh"

module eeprom_host #(
    parameter int unsigned PAGE_GAP_CYC = `PAGE_GAP_CYC,
    parameter int unsigned PROG_MAX_CYC = `PROG_MAX_CYC
) (
    // Clock and reset.
    input  wire logic                      ref_clk_i,
    input  wire logic                      srst_i,
    // User request and answer.
    input  wire eeprom_host_pkg::host_req_t req_i,
    output logic                           req_ready_o,
    output eeprom_host_pkg::host_rsp_t     rsp_o,
    // Memory pins.
    output eeprom_host_pkg::mem_pins_t     pins_o,
    input  wire logic [7:0]                bidir_byte_lines_i
);
    import eeprom_host_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        S_IDLE   = 7'b000_0001,
        S_RD     = 7'b000_0010,
        S_WSET   = 7'b000_0100,
        S_WLOW   = 7'b000_1000,
        S_WHIGH  = 7'b001_0000,
        S_PAGE   = 7'b010_0000,
        S_POLL   = 7'b100_0000
    } fsm_t;

    typedef struct packed {
        fsm_t        fsm;
        logic [31:0] cnt;
        logic [31:0] gap;
        logic [3:0]  nbytes;
        logic [6:0]  page;
        logic        wlast;
        logic [7:0]  lastdat;
        logic [10:0] lastadr;
        host_rsp_t   rsp;
        mem_pins_t   pins;
    } state_t;

    state_t s_q;
    state_t s_d;

    localparam int unsigned STROBE_CYC = `STROBE_CYC;
    localparam int unsigned ACCESS_CYC = `ACCESS_CYC;

    // A page may take a new byte only in the page state and within the same upper address.
    function automatic logic same_page(input logic [10:0] a, input logic [6:0] p);
        same_page = (a[10:`PAGE_LSB_W] == p);
    endfunction

    // A page byte is only offered while its strobe can still fall inside the gap limit.
    assign req_ready_o = (s_q.fsm == S_IDLE) ||
                         ((s_q.fsm == S_PAGE) && req_i.write && same_page(req_i.addr, s_q.page)
                          && (s_q.gap + 32'(STROBE_CYC) + 32'd4 < PAGE_GAP_CYC));
    assign rsp_o  = s_q.rsp;
    assign pins_o = s_q.pins;

    always_comb begin
        s_d = s_q;
        s_d.rsp.done = 1'b0;
        s_d.rsp.timeout = 1'b0;
        s_d.cnt = s_q.cnt + 32'h0000_0001;
        s_d.gap = s_q.gap + 32'h0000_0001;
        unique case (s_q.fsm)
            S_IDLE: begin
                // Select high keeps the device in standby between operations.
                s_d.pins.cs_n = 1'b1;
                s_d.pins.oe_n = 1'b1;
                s_d.pins.we_n = 1'b1;
                s_d.pins.doe  = 1'b0;
                if (req_i.valid) begin
                    s_d.pins.byte_address_lines = req_i.addr;
                    s_d.cnt = 32'h0000_0000;
                    if (req_i.write) begin
                        s_d.pins.dout = req_i.wdata;
                        s_d.page      = req_i.addr[10:`PAGE_LSB_W];
                        s_d.nbytes    = 4'h0;
                        s_d.wlast     = req_i.last;
                        s_d.pins.cs_n = 1'b0;
                        s_d.pins.doe  = 1'b1;
                        s_d.fsm       = S_WSET;
                    end else begin
                        s_d.pins.cs_n = 1'b0;
                        s_d.pins.oe_n = 1'b0;
                        s_d.fsm       = S_RD;
                    end
                end
            end
            S_RD, S_POLL: begin
                if (s_q.cnt >= 32'(ACCESS_CYC)) begin
                    s_d.pins.cs_n = 1'b1;
                    s_d.pins.oe_n = 1'b1;
                    s_d.cnt = 32'h0000_0000;
                    if (s_q.fsm == S_RD) begin
                        s_d.rsp.rdata = bidir_byte_lines_i;
                        s_d.rsp.done  = 1'b1;
                        s_d.fsm       = S_IDLE;
                    end else if (bidir_byte_lines_i[`POLL_BIT] == s_q.lastdat[`POLL_BIT]) begin
                        // Bit seven equal to bit seven of the last written byte means programming is over.
                        s_d.rsp.rdata = bidir_byte_lines_i;
                        s_d.rsp.done  = 1'b1;
                        s_d.fsm       = S_IDLE;
                    end else if (s_q.gap >= PROG_MAX_CYC) begin
                        s_d.rsp.timeout = 1'b1;
                        s_d.rsp.done    = 1'b1;
                        s_d.fsm         = S_IDLE;
                    end
                end else if (s_q.cnt == 32'h0000_0001) begin
                    s_d.pins.cs_n = 1'b0;
                    s_d.pins.oe_n = 1'b0;
                end
            end
            S_WSET: begin
                // Strobe falls after select so the address is stable at the latch edge.
                s_d.pins.we_n = 1'b0;
                s_d.gap = 32'h0000_0000;
                s_d.cnt = 32'h0000_0000;
                s_d.fsm = S_WLOW;
            end
            S_WLOW: begin
                // A long strobe keeps well clear of the device's glitch filter.
                if (s_q.cnt >= 32'(STROBE_CYC)) begin
                    s_d.pins.we_n = 1'b1;
                    s_d.cnt = 32'h0000_0000;
                    s_d.fsm = S_WHIGH;
                end
            end
            S_WHIGH: begin
                s_d.pins.cs_n = 1'b1;
                s_d.pins.doe  = 1'b0;
                s_d.lastdat   = s_q.pins.dout;
                s_d.lastadr   = s_q.pins.byte_address_lines;
                s_d.nbytes    = s_q.nbytes + 4'h1;
                s_d.fsm       = s_q.wlast ? S_POLL : S_PAGE;
                s_d.cnt       = 32'h0000_0000;
                if (s_q.wlast) begin
                    s_d.pins.byte_address_lines = s_q.pins.byte_address_lines;
                end
            end
            S_PAGE: begin
                // The page closes on its own once the gap limit would be missed.
                if (req_ready_o && req_i.valid) begin
                    s_d.pins.byte_address_lines = req_i.addr;
                    s_d.pins.dout = req_i.wdata;
                    s_d.wlast     = req_i.last || (s_q.nbytes == 4'hF);
                    s_d.pins.cs_n = 1'b0;
                    s_d.pins.doe  = 1'b1;
                    s_d.fsm       = S_WSET;
                end else if (s_q.gap + 32'(STROBE_CYC) + 32'd4 >= PAGE_GAP_CYC) begin
                    s_d.pins.byte_address_lines = s_q.lastadr;
                    s_d.cnt = 32'h0000_0000;
                    s_d.fsm = S_POLL;
                end
            end
            default: s_d.fsm = S_IDLE;
        endcase
        if (s_q.fsm == S_POLL || s_q.fsm == S_RD) begin
            s_d.pins.we_n = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_q <= '0;
            s_q.fsm <= S_IDLE;
            s_q.pins.cs_n <= 1'b1;
            s_q.pins.oe_n <= 1'b1;
            s_q.pins.we_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_rd_ctrl;
        @(posedge ref_clk_i) disable iff (srst_i)
        (!pins_o.oe_n) |-> (pins_o.we_n && !pins_o.doe);
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("read with strobe or drive");

    property p_wr_ctrl;
        @(posedge ref_clk_i) disable iff (srst_i)
        (!pins_o.we_n) |-> (!pins_o.cs_n && pins_o.oe_n && pins_o.doe);
    endproperty
    a_wr_ctrl: assert property (p_wr_ctrl) else $error("bad write control");

    property p_addr_stable;
        @(posedge ref_clk_i) disable iff (srst_i)
        (!pins_o.we_n && $past(!pins_o.we_n)) |-> $stable(pins_o.byte_address_lines);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved");

    property p_data_hold;
        @(posedge ref_clk_i) disable iff (srst_i)
        $rose(pins_o.we_n) |-> (pins_o.doe && $stable(pins_o.dout));
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data not held");

    property p_strobe_len;
        @(posedge ref_clk_i) disable iff (srst_i)
        $fell(pins_o.we_n) |-> !pins_o.we_n [*3];
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe too short");

    property p_page_same;
        @(posedge ref_clk_i) disable iff (srst_i)
        $fell(pins_o.we_n) |-> same_page(pins_o.byte_address_lines, s_q.page);
    endproperty
    a_page_same: assert property (p_page_same) else $error("page changed");

    property p_gap;
        @(posedge ref_clk_i) disable iff (srst_i)
        ($fell(pins_o.we_n) && $past(s_q.nbytes) != 4'h0) |-> ($past(s_q.gap) < PAGE_GAP_CYC);
    endproperty
    a_gap: assert property (p_gap) else $error("page gap exceeded");

    property p_no_write_in_poll;
        @(posedge ref_clk_i) disable iff (srst_i)
        (s_q.fsm == S_POLL) |-> pins_o.we_n;
    endproperty
    a_no_write_in_poll: assert property (p_no_write_in_poll) else $error("write during poll");

    c_read:  cover property (@(posedge ref_clk_i) s_q.fsm == S_RD ##1 s_q.fsm == S_IDLE);
    c_page:  cover property (@(posedge ref_clk_i) s_q.fsm == S_PAGE ##1 s_q.fsm == S_WSET);
    c_close: cover property (@(posedge ref_clk_i) s_q.fsm == S_PAGE ##1 s_q.fsm == S_POLL);
    c_tmo:   cover property (@(posedge ref_clk_i) rsp_o.timeout);
endmodule
`default_nettype wire

/* verif/eeprom_dev_model.sv */
// Pin-level behavioural model of the byte-wide EEPROM.
`timescale 1ns/10ps
`default_nettype none
module eeprom_dev_model #(
    parameter longint GAP_NS  = 1200,
    parameter longint PROG_NS = 5000
) (
    // Control pins, active low.
    input  wire logic        cs_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    // Address, data and a stall control for the timeout case.
    input  wire logic [10:0] addr_i,
    input  wire logic [7:0]  din_i,
    input  wire logic        hang_i,
    output logic      [7:0]  dout_o,
    output logic             drive_o
);
    logic   [7:0]  mem [2048];
    logic   [7:0]  pbuf [16];
    logic   [15:0] pval = 16'h0000;
    logic   [10:0] laddr = 11'h000;
    logic   [10:0] waddr = 11'h000;
    logic   [7:0]  wdat = 8'h00;
    logic          busy = 1'b0;
    logic          armed = 1'b0;
    longint        t_fall = 0;
    longint        t_end = 0;
    wire           wsel = ~cs_n_i & ~we_n_i & oe_n_i;
    initial for (int i = 0; i < 2048; i++) mem[i] = 8'hFF;
    // Address is taken when the later of select and strobe falls.
    always @(posedge wsel) begin
        laddr = addr_i;
        t_fall = $time;
        armed = 1'b1;
    end
    // Data is taken when the first of them rises; glitches and unknown addresses are dropped.
    // A fall with no rise before it, as when the pins leave unknown at power-up, loads nothing.
    always @(negedge wsel) begin
        if (armed && !busy && ^laddr !== 1'bx && $time - t_fall >= 10) begin
            pbuf[laddr[3:0]] = din_i;
            pval[laddr[3:0]] = 1'b1;
            waddr = laddr;
            wdat = din_i;
        end
        armed = 1'b0;
    end
    // A quiet gap closes the page; programming then times itself.
    always #10 begin
        if (!busy && pval != 16'h0000 && !wsel && $time - t_fall >= GAP_NS) begin
            busy = 1'b1;
            t_end = $time + PROG_NS;
        end else if (busy && !hang_i && $time >= t_end) begin
            for (int i = 0; i < 16; i++)
                if (pval[i]) mem[{waddr[10:4], i[3:0]}] = pbuf[i];
            pval = 16'h0000;
            busy = 1'b0;
        end
    end
    assign drive_o = ~cs_n_i & ~oe_n_i & we_n_i;
    assign dout_o = (busy && addr_i == waddr) ?
                    {~wdat[7], wdat[6:0]} : mem[addr_i];
endmodule
`default_nettype wire

/* verif/eeprom_host_test.sv */
// Self-checking bench for the EEPROM host controller against a pin model.
`timescale 1ns/10ps
`default_nettype none
module eeprom_host_test;
    import eeprom_host_pkg::*;
    localparam int unsigned GAP_CYC  = 60;
    localparam int unsigned PMAX_CYC = 2000;
    localparam int          PROG_CYC = 250;
    logic       ref_clk_i = 1'b0;
    logic       srst_i = 1'b1;
    logic       req_ready_o;
    logic       drive;
    logic       hang = 1'b0;
    logic       last_to = 1'b0;
    logic [7:0] bus;
    logic [7:0] bus_q = 8'h00;
    logic [7:0] dev_dout;
    host_req_t  req_i = '0;
    host_rsp_t  rsp_o;
    mem_pins_t  pins_o;
    int         errors = 0;
    int         checks = 0;
    int         n_done = 0;
    int         cyc = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    // A floating bus shows the inverse of its last value, so stale data cannot pass.
    assign bus = pins_o.doe ? pins_o.dout : (drive ? dev_dout : ~bus_q);
    eeprom_host #(.PAGE_GAP_CYC(GAP_CYC), .PROG_MAX_CYC(PMAX_CYC)) i_eeprom_host (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .rsp_o(rsp_o), .pins_o(pins_o), .bidir_byte_lines_i(bus));
    eeprom_dev_model #(.GAP_NS(GAP_CYC * 20), .PROG_NS(PROG_CYC * 20)) i_eeprom_dev_model (
        .cs_n_i(pins_o.cs_n), .oe_n_i(pins_o.oe_n), .we_n_i(pins_o.we_n),
        .addr_i(pins_o.byte_address_lines), .din_i(pins_o.dout), .hang_i(hang),
        .dout_o(dev_dout), .drive_o(drive));
    always @(posedge ref_clk_i) begin
        if (!$isunknown(bus)) bus_q <= bus;
        cyc <= cyc + 1;
        if (rsp_o.done === 1'b1) begin
            n_done <= n_done + 1;
            last_to <= rsp_o.timeout;
        end
        if (pins_o.doe === 1'b1 && drive === 1'b1) check("contention", 0, 1);
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input logic wr, lst, input logic [10:0] a, input logic [7:0] d,
                        input logic drop);
        int n;
        req_i = '{valid: 1'b1, write: wr, last: lst, addr: a, wdata: d};
        #1;
        for (n = 0; n < 9000 && req_ready_o !== 1'b1; n++) @(negedge ref_clk_i);
        if (n == 9000) check("take", 1, 0);
        @(negedge ref_clk_i);
        if (drop) req_i.valid = 1'b0;
    endtask
    task automatic wait_done(input int base);
        int n;
        for (n = 0; n < 9000 && n_done == base; n++) @(negedge ref_clk_i);
        check("done", base + 1, n_done);
    endtask
    task automatic read_chk(input logic [10:0] a, input logic [7:0] exp);
        int base;
        base = n_done;
        send(1'b0, 1'b0, a, 8'h00, 1'b1);
        wait_done(base);
        check("rdata", exp, rsp_o.rdata);
    endtask
    task automatic t_reset();
        repeat (3) @(negedge ref_clk_i);
        check("idle_pins", 4'hE, {pins_o.cs_n, pins_o.oe_n, pins_o.we_n, pins_o.doe});
        srst_i = 1'b0;
    endtask
    task automatic t_byte();
        int base;
        int t0;
        base = n_done;
        t0 = cyc;
        send(1'b1, 1'b1, 11'h005, 8'h3C, 1'b1);
        wait_done(base);
        check("poll_wait", 1, cyc - t0 >= PROG_CYC);
        check("timeout", 0, last_to);
        read_chk(11'h005, 8'h3C);
        read_chk(11'h7FF, 8'hFF);
    endtask
    // Sixteen bytes with the last flag never set: the page must close itself.
    task automatic t_page();
        int base;
        base = n_done;
        for (int i = 0; i < 16; i++) send(1'b1, 1'b0, 11'(11'h7F0 + i), 8'(8'h10 + i), i == 15);
        wait_done(base);
        read_chk(11'h7F0, 8'h10);
        read_chk(11'h7FF, 8'h1F);
        read_chk(11'h7EF, 8'hFF);
    endtask
    task automatic t_gap();
        int base;
        base = n_done;
        send(1'b1, 1'b0, 11'h100, 8'h21, 1'b0);
        send(1'b1, 1'b0, 11'h101, 8'h22, 1'b0);
        send(1'b1, 1'b1, 11'h230, 8'h42, 1'b1);
        check("gap_close", base + 1, n_done);
        wait_done(base + 1);
        read_chk(11'h100, 8'h21);
        read_chk(11'h101, 8'h22);
        read_chk(11'h230, 8'h42);
    endtask
    task automatic t_hang();
        int base;
        hang = 1'b1;
        base = n_done;
        send(1'b1, 1'b1, 11'h050, 8'h01, 1'b1);
        wait_done(base);
        check("timeout", 1, last_to);
        hang = 1'b0;
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        t_reset();
        t_byte();
        t_page();
        t_gap();
        t_hang();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
